/* File: cache_copyback_invalidate_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cache_copyback_invalidate_sequencer_test;
  import ccs_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 12'h040;
  localparam logic [ADDR_W-1:0] BC = 12'h180;
  logic clk, rstn, pready, pslverr, core_req, sys_req, fetch_req;
  logic core_gnt, sys_gnt, fetch_gnt, way_dirty, step_we, cb_valid;
  logic cb_ready, exc, slow, cb_bad, rdy, er, ce;
  logic [3:0] exc_cause;
  logic [9:0] cb_cnt;
  logic [8:0] exp_pos;
  logic [31:0] prdata, rd;
  ccs_apb_req_t apb;
  ccs_step_t step;
  int err_count, checks_done, acc, stall_cyc, step_cyc, inv_cnt;
  int fetch_cyc, exc_cnt;

  ccs_seq #(.BLOCK_ID(4'h2)) u_ccs_seq (.core_clk_i(clk), .rstn_i(rstn),
    .ce_i(ce), .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .core_req_i(core_req), .sys_req_i(sys_req),
    .fetch_req_i(fetch_req), .core_gnt_o(core_gnt), .sys_gnt_o(sys_gnt),
    .fetch_gnt_o(fetch_gnt), .way_dirty_i(way_dirty), .step_o(step),
    .step_we_o(step_we), .cb_valid_o(cb_valid), .cb_ready_i(cb_ready),
    .exc_o(exc), .exc_cause_o(exc_cause));
  ccs_way_model u_ccs_way_model (.core_clk_i(clk), .rstn_i(rstn),
    .step_i(step), .step_we_i(step_we), .way_dirty_o(way_dirty),
    .cb_valid_i(cb_valid), .slow_i(slow), .cb_ready_o(cb_ready),
    .cb_cnt_o(cb_cnt), .cb_bad_o(cb_bad));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude;
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [31:0] cmd(logic [7:0] op, int len, logic ns);
    return {op, 24'h0} | (32'(len) << LEN_LSB) | (32'(ns) << NO_STALL_BIT);
  endfunction

  // one apb transfer; the answer is taken at the edge where pready is high
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] b,
                      input logic [4:0] o, input logic [31:0] d);
    acc = 0;
    apb <= '{1'b1, 1'b0, w, b | 12'(o), d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
      acc++;
    end while (rdy !== 1'b1 && acc < 400);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    // one idle edge so the next request never overwrites this release
    @(posedge clk);
    if (rdy !== 1'b1) begin
      err_count++;
      conclude();
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, BASE, OFF_STATUS, 32'h0);
      n++;
    end while (rd[STAT_ACTIVE_BIT] !== 1'b0 && n < 500);
    chk("active", 32'(rd[STAT_ACTIVE_BIT]), 32'h0);
    if (rd[STAT_ACTIVE_BIT] !== 1'b0) conclude();
  endtask

  always @(posedge clk) begin
    if (apb.psel && apb.penable && !pready) stall_cyc++;
    if (step_we && core_req) step_cyc++;
    if (fetch_gnt) fetch_cyc++;
    if (exc && exc_cause === EXC_CAUSE) exc_cnt++;
    if (step_we && step.inval) begin
      chk("inval pos", 32'({step.set, step.way}), 32'(exp_pos));
      chk("inval tag", 32'(step.tag), 32'(4'h1 << step.way));
      exp_pos <= exp_pos + 9'h1;
      inv_cnt++;
    end
  end

  task automatic t_basic;
    xfer(1'b0, BASE, OFF_STATUS, 32'h0);
    chk("status reset", rd, 32'h0);
    xfer(1'b0, 12'h200, OFF_CMD, 32'h0);
    chk("unmapped err", 32'(er), 32'h1);
    xfer(1'b1, BASE, OFF_CMD, cmd(8'h20, 3, 1'b0));
    xfer(1'b0, BASE, OFF_STATUS, 32'h0);
    chk("bad opcode", 32'(rd[STAT_ACTIVE_BIT]), 32'h0);
    core_req <= 1'b1;
    sys_req <= 1'b1;
    @(posedge clk);
    chk("core gnt", 32'(core_gnt), 32'h1);
    chk("sys under core", 32'(sys_gnt), 32'h0);
    core_req <= 1'b0;
    @(posedge clk);
    chk("sys gnt", 32'(sys_gnt), 32'h1);
    sys_req <= 1'b0;
  endtask

  task automatic t_copyback;
    u_ccs_way_model.dirty_ff = '0;
    u_ccs_way_model.dirty_ff[28:19] = 10'b1_0100_1101_1;
    slow <= 1'b1;
    xfer(1'b1, BASE, OFF_START, 32'h0002_17ff);
    xfer(1'b1, BC, OFF_CMD, cmd(OPC_COPYBACK, 7, 1'b0));
    xfer(1'b0, BASE, OFF_STATUS, 32'h0);
    chk("active run", 32'(rd[STAT_ACTIVE_BIT]), 32'h1);
    wait_idle();
    chk("cb count", 32'(cb_cnt), 32'h4);
    chk("cb clean", 32'(cb_bad), 32'h0);
    chk("dirty left", 32'(u_ccs_way_model.dirty_ff[28:19]), 32'h201);
  endtask

  task automatic t_inval;
    int frozen;
    u_ccs_way_model.dirty_ff = '1;
    fetch_req <= 1'b1;
    exp_pos <= 9'h1f8;
    inv_cnt = 0;
    xfer(1'b1, BASE, OFF_PAIR_LO, cmd(OPC_INVAL, 11, 1'b0));
    xfer(1'b1, BASE, OFF_PAIR_HI, 32'(7'd126) << IDX_LSB);
    // clock enable low must freeze the walk mid-command
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    frozen = inv_cnt;
    repeat (3) @(posedge clk);
    chk("ce freeze", 32'(inv_cnt - frozen), 32'h0);
    ce <= 1'b1;
    wait_idle();
    fetch_req <= 1'b0;
    chk("inval count", 32'(inv_cnt), 32'd12);
    chk("fetch shared", 32'(fetch_cyc > 0), 32'h1);
    chk("inval wrap", 32'(u_ccs_way_model.dirty_ff[7:0]), 32'hf0);
  endtask

  task automatic t_stall;
    u_ccs_way_model.dirty_ff[3:0] = 4'hf;
    stall_cyc = 0;
    xfer(1'b1, BASE, OFF_START, 32'h0);
    xfer(1'b1, BASE, OFF_CMD, cmd(OPC_COPYBACK, 3, 1'b0));
    xfer(1'b1, BASE, OFF_START, 32'h0);
    chk("stalled", 32'(stall_cyc > 0), 32'h1);
    chk("stall err", 32'(er), 32'h0);
    xfer(1'b0, BASE, OFF_STATUS, 32'h0);
    chk("done on exit", 32'(rd[STAT_ACTIVE_BIT]), 32'h0);
  endtask

  task automatic t_abort;
    u_ccs_way_model.dirty_ff[0] = 1'b1;
    core_req <= 1'b1;
    step_cyc = 0;
    exc_cnt = 0;
    xfer(1'b1, BASE, OFF_CMD, cmd(OPC_COPYBACK, 0, 1'b1));
    xfer(1'b1, BASE, OFF_START, 32'h0);
    chk("abort err", 32'(er), 32'h1);
    chk("abort wait", 32'(acc), 32'd10);
    repeat (3) @(posedge clk);
    chk("exception", 32'(exc_cnt), 32'h1);
    xfer(1'b0, BASE, OFF_STATUS, 32'h0);
    chk("abort flag", 32'(rd[STAT_ABORT_BIT]), 32'h1);
    chk("core first", 32'(step_cyc), 32'h0);
    core_req <= 1'b0;
    wait_idle();
    chk("abort clr", 32'(rd[STAT_ABORT_BIT]), 32'h0);
  endtask

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    apb = '0;
    core_req = 1'b0;
    sys_req = 1'b0;
    fetch_req = 1'b0;
    slow = 1'b0;
    exp_pos = '0;
    u_ccs_way_model.dirty_ff = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_basic();
    t_copyback();
    t_inval();
    t_stall();
    t_abort();
    conclude();
  end
endmodule // cache_copyback_invalidate_sequencer_test
`default_nettype wire

/* File: ccs_arb.sv */
`timescale 1ns/1ps
`default_nettype none
module ccs_arb (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // requests
  input wire logic core_req_i,
  input wire logic sys_req_i,
  input wire logic fetch_req_i,
  input wire logic seq_req_i,
  // grants
  output logic core_gnt_o,
  output logic sys_gnt_o,
  output logic fetch_gnt_o,
  output logic seq_gnt_o
);
  logic prefer_fetch_ff;
  logic hi_busy;
  logic conflict;

  // core and system first, then fetch and sequencer share a turn
  assign hi_busy = core_req_i | sys_req_i;
  assign conflict = ~hi_busy & fetch_req_i & seq_req_i;
  assign core_gnt_o = core_req_i;
  assign sys_gnt_o = sys_req_i & ~core_req_i;
  assign fetch_gnt_o = ~hi_busy & fetch_req_i & (~seq_req_i | prefer_fetch_ff);
  assign seq_gnt_o = ~hi_busy & seq_req_i & (~fetch_req_i | ~prefer_fetch_ff);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      prefer_fetch_ff <= 1'b1;
    end else if (ce_i && conflict) begin
      prefer_fetch_ff <= ~prefer_fetch_ff; // R10
    end
  end
endmodule // ccs_arb
`default_nettype wire

/* File: ccs_pkg.sv */
package ccs_pkg;
  // apb map
  localparam int ADDR_W = 12;
  localparam logic [3:0] SLOT_BCAST = 4'hc;
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_START = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_PAIR_LO = 5'h0c;
  localparam logic [4:0] OFF_PAIR_HI = 5'h10;
  // command word fields
  localparam int OPC_LSB = 24;
  localparam int OPC_MSB = 31;
  localparam logic [7:0] OPC_COPYBACK = 8'h10;
  localparam logic [7:0] OPC_INVAL = 8'h14;
  localparam int LEN_LSB = 15;
  localparam int LEN_MSB = 23;
  localparam int NO_STALL_BIT = 14;
  localparam int IDX_LSB = 10;
  localparam int IDX_MSB = 16;
  // status bits
  localparam int STAT_ACTIVE_BIT = 16;
  localparam int STAT_ABORT_BIT = 17;
  localparam int STAT_STALL_BIT = 19;
  // timing and codes
  localparam logic [3:0] ABORT_WAIT = 4'h8;
  localparam logic [3:0] ABORT_AT = ABORT_WAIT + 4'h1;
  localparam logic [3:0] EXC_CAUSE = 4'ha;
  localparam logic [3:0] INV_TAG_WAY0 = 4'h1;
  localparam logic [1:0] LAST_WAY = 2'h3;
  localparam logic [31:0] RD_ZERO = 32'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STEP = 3'b010,
    ST_PUSH = 3'b100
  } ccs_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } ccs_apb_req_t;

  typedef struct packed {
    logic [6:0] set;
    logic [1:0] way;
    logic inval;
    logic clr_dirty;
    logic [3:0] tag;
  } ccs_step_t;
endpackage

/* File: ccs_seq.sv */
// What this block does
// [R1] copyback writes only dirty ways to memory; clean ways cause no write
// [R2] dirty flag clears when the way is handed to the copyback buffer
// [R3] start index is seven bits taken from bits 16 to 10
// [R4] length field bits 23 to 15 gives ways to process minus one
// [R5] bit 14 low: busy writes stall, status bit 19 shows stalling
// [R6] bit 14 high: write waiting over eight cycles aborts, bit 17, cause 0b1010
// [R7] status bit 16 stays set while a command runs
// [R8] walk sets from start index, four ways per set
// [R9] core and system accesses always win over command steps
// [R10] instruction fetch and command steps alternate on conflict
// [R11] copyback runs whether the cache is enabled or not
// [R12] invalidate clears way state and writes tag one-hot by way
// [R13] software disables the cache before invalidating
// [R14] invalidate is the only path that clears a lock flag
// [R15] opcode 0x10000000 means copyback
// [R16] opcode 0x14000000 means invalidate
// [R17] per-block registers plus a broadcast copy reaching every block
// [R18] a pair write loads command and start index together
// [R19] software writes start index before the command
// [R20] software avoids the index range being processed
// [R21] active clears the cycle after the last way, back to idle
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ccs_seq
  import ccs_pkg::*;
#(
  parameter logic [3:0] BLOCK_ID = 4'h0
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // apb slave
  input wire ccs_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // competing cache requesters
  input wire logic core_req_i,
  input wire logic sys_req_i,
  input wire logic fetch_req_i,
  output logic core_gnt_o,
  output logic sys_gnt_o,
  output logic fetch_gnt_o,
  // way state array
  input wire logic way_dirty_i,
  output ccs_step_t step_o,
  output logic step_we_o,
  // copyback buffer
  output logic cb_valid_o,
  input wire logic cb_ready_i,
  // memory system exception
  output logic exc_o,
  output logic [3:0] exc_cause_o
);
  ccs_state_t state_ff;
  ccs_state_t nxt_state;
  logic [6:0] start_ff;
  logic [31:0] pair_lo_ff;
  logic [6:0] set_ff;
  logic [1:0] way_ff;
  logic [8:0] rem_ff;
  logic inv_ff;
  logic no_stall_ff;
  logic [3:0] wait_ff;
  logic stall_ff;
  logic abort_ff;
  logic exc_ff;
  logic [3:0] exc_cause_ff;

  logic [3:0] slot;
  logic [4:0] off;
  logic hit;
  logic mapped;
  logic acc;
  logic launch_reg;
  logic busy_wr;
  logic abort_now;
  logic stall_now;
  logic take;
  logic stat_rd;
  logic cmd_wr;
  logic [31:0] cmd_word;
  logic [6:0] cmd_idx;
  logic [7:0] opc;
  logic launch;
  logic st_idle;
  logic st_step;
  logic st_push;
  logic seq_gnt;
  logic go_push;
  logic cb_fire;
  logic adv;
  logic last;
  logic [31:0] status;

  // address decode: own slot or the broadcast slot
  assign slot = apb_i.paddr[8:5];
  assign off = apb_i.paddr[4:0];
  assign hit = (apb_i.paddr[ADDR_W-1:9] == 3'h0)
             & ((slot == BLOCK_ID) | (slot == SLOT_BCAST)); // R17
  assign mapped = hit & ((off == OFF_CMD) | (off == OFF_START)
                       | (off == OFF_STATUS) | (off == OFF_PAIR_LO)
                       | (off == OFF_PAIR_HI));
  assign acc = ce_i & apb_i.psel & apb_i.penable;
  assign launch_reg = (off == OFF_CMD) | (off == OFF_START)
                    | (off == OFF_PAIR_HI);

  // writes that reach command or start index while a command runs
  assign busy_wr = acc & apb_i.pwrite & mapped & launch_reg & ~st_idle;
  assign abort_now = busy_wr & no_stall_ff & (wait_ff == ABORT_AT); // R6
  assign stall_now = busy_wr & ~abort_now; // R5
  assign take = acc & apb_i.pwrite & mapped & ~busy_wr;
  assign stat_rd = acc & ~apb_i.pwrite & mapped & (off == OFF_STATUS);

  assign pready_o = ce_i & ~stall_now;
  assign pslverr_o = acc & (~mapped | abort_now);

  assign status = {12'h000, stall_ff, 1'b0, abort_ff, ~st_idle, 16'h0000};
  assign prdata_o = (acc & ~apb_i.pwrite & mapped & (off == OFF_STATUS))
                  ? status : RD_ZERO;

  // a pair write takes the staged low word and the start index at once
  assign cmd_wr = take & ((off == OFF_CMD) | (off == OFF_PAIR_HI));
  assign cmd_word = (off == OFF_PAIR_HI) ? pair_lo_ff : apb_i.pwdata; // R18
  assign cmd_idx = (off == OFF_PAIR_HI)
                 ? apb_i.pwdata[IDX_MSB:IDX_LSB] : start_ff; // R18
  assign opc = cmd_word[OPC_MSB:OPC_LSB];
  assign launch = cmd_wr & ((opc == OPC_COPYBACK) | (opc == OPC_INVAL));

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      start_ff <= 7'h00;
    end else if (take && (off == OFF_START)) begin
      start_ff <= apb_i.pwdata[IDX_MSB:IDX_LSB]; // R3
    end else if (take && (off == OFF_PAIR_HI)) begin
      start_ff <= apb_i.pwdata[IDX_MSB:IDX_LSB]; // R3
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pair_lo_ff <= 32'h0;
    end else if (take && (off == OFF_PAIR_LO)) begin
      pair_lo_ff <= apb_i.pwdata;
    end
  end

  // wait counter for a write held off by a running command
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wait_ff <= 4'h0;
    end else if (ce_i) begin
      if (stall_now && no_stall_ff) begin
        wait_ff <= wait_ff + 4'h1; // R6
      end else begin
        wait_ff <= 4'h0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      stall_ff <= 1'b0;
    end else if (ce_i) begin
      stall_ff <= stall_now & ~no_stall_ff; // R5
    end
  end

  // abort flag: set wins over the clear-on-read
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      abort_ff <= 1'b0;
    end else if (abort_now) begin
      abort_ff <= 1'b1; // R6
    end else if (stat_rd) begin
      abort_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      exc_ff <= 1'b0;
      exc_cause_ff <= 4'h0;
    end else if (ce_i) begin
      exc_ff <= abort_now; // R6
      if (abort_now) begin
        exc_cause_ff <= EXC_CAUSE; // R6
      end
    end
  end
  assign exc_o = exc_ff;
  assign exc_cause_o = exc_cause_ff;

  // sequencer
  assign st_idle = (state_ff == ST_IDLE);
  assign st_step = (state_ff == ST_STEP);
  assign st_push = (state_ff == ST_PUSH);
  assign last = (rem_ff == 9'h000);

  ccs_arb u_arb (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .core_req_i(core_req_i),
    .sys_req_i(sys_req_i),
    .fetch_req_i(fetch_req_i),
    .seq_req_i(st_step | st_push),
    .core_gnt_o(core_gnt_o),
    .sys_gnt_o(sys_gnt_o),
    .fetch_gnt_o(fetch_gnt_o),
    .seq_gnt_o(seq_gnt)
  ); // R9 R10

  // copyback ignores the cache enable entirely
  assign go_push = ce_i & st_step & seq_gnt & ~inv_ff & way_dirty_i; // R1 R11
  assign cb_valid_o = st_push & seq_gnt; // R1
  assign cb_fire = ce_i & cb_valid_o & cb_ready_i;
  assign adv = ce_i & ((st_step & seq_gnt & (inv_ff | ~way_dirty_i))
                     | (st_push & seq_gnt & cb_ready_i));

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (launch) begin
          nxt_state = ST_STEP;
        end
      end
      ST_STEP: begin
        if (go_push) begin
          nxt_state = ST_PUSH;
        end else if (adv && last) begin
          nxt_state = ST_IDLE; // R21
        end
      end
      ST_PUSH: begin
        if (adv && last) begin
          nxt_state = ST_IDLE; // R21
        end else if (adv) begin
          nxt_state = ST_STEP;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_ff <= ST_IDLE;
    end else if (ce_i) begin
      state_ff <= nxt_state; // R7
    end
  end

  // range walk: four ways per set, then the next set
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      set_ff <= 7'h00;
      way_ff <= 2'h0;
      rem_ff <= 9'h000;
      inv_ff <= 1'b0;
      no_stall_ff <= 1'b0;
    end else if (st_idle && launch) begin
      set_ff <= cmd_idx; // R8
      way_ff <= 2'h0;
      rem_ff <= cmd_word[LEN_MSB:LEN_LSB]; // R4
      inv_ff <= (opc == OPC_INVAL); // R15 R16
      no_stall_ff <= cmd_word[NO_STALL_BIT]; // R5
    end else if (adv) begin
      rem_ff <= rem_ff - 9'h001; // R4
      way_ff <= way_ff + 2'h1; // R8
      if (way_ff == LAST_WAY) begin
        set_ff <= set_ff + 7'h01; // R8
      end
    end
  end

  // invalidate clears lru, lock, dirty, valid and sets a one-hot tag
  assign step_o.set = set_ff;
  assign step_o.way = way_ff;
  assign step_o.inval = inv_ff; // R12 R14
  assign step_o.clr_dirty = ~inv_ff; // R2
  assign step_o.tag = INV_TAG_WAY0 << way_ff; // R12
  assign step_we_o = (ce_i & st_step & seq_gnt & inv_ff) | cb_fire; // R2

  default clocking dcb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_clean_no_push;
    st_step && seq_gnt && !inv_ff && !way_dirty_i && ce_i |=> !st_push;
  endproperty
  a_clean_no_push: assert property (p_clean_no_push) // R1
    else $error("clean way pushed to copyback buffer");

  property p_dirty_clear;
    cb_valid_o && cb_ready_i && ce_i |-> step_we_o && step_o.clr_dirty
      && !step_o.inval;
  endproperty
  a_dirty_clear: assert property (p_dirty_clear) // R2
    else $error("dirty flag not cleared at handoff");

  property p_start_idx;
    take && (off == OFF_START) |=> start_ff == $past(apb_i.pwdata[16:10]);
  endproperty
  a_start_idx: assert property (p_start_idx) // R3
    else $error("start index not taken from bits 16 to 10");

  property p_length;
    st_idle && launch && (off == OFF_CMD)
      |=> rem_ff == $past(apb_i.pwdata[23:15]) && !st_idle;
  endproperty
  a_length: assert property (p_length) // R4
    else $error("length field not loaded");

  property p_stall;
    busy_wr && !no_stall_ff |-> !pready_o ##1 stall_ff;
  endproperty
  a_stall: assert property (p_stall) // R5
    else $error("stall mode write not held off");

  property p_abort;
    abort_now |-> pready_o && pslverr_o
      ##1 abort_ff && exc_o && (exc_cause_o == 4'ha);
  endproperty
  a_abort: assert property (p_abort) // R6
    else $error("abort not flagged or exception missing");

  property p_abort_late;
    busy_wr && no_stall_ff && (wait_ff < 4'h9) |-> !pready_o;
  endproperty
  a_abort_late: assert property (p_abort_late) // R6
    else $error("write aborted before nine waiting cycles");

  property p_set_step;
    adv && (way_ff == 2'h3) && !last
      |=> (way_ff == 2'h0) && (set_ff == $past(set_ff) + 7'h01);
  endproperty
  a_set_step: assert property (p_set_step) // R8
    else $error("set did not advance after fourth way");

  property p_priority;
    core_req_i || sys_req_i |-> !seq_gnt && !fetch_gnt_o;
  endproperty
  a_priority: assert property (p_priority) // R9
    else $error("command step granted over core or system");

  property p_rr;
    (ce_i && seq_gnt && fetch_req_i) ##1
      (!core_req_i && !sys_req_i && fetch_req_i && (st_step || st_push))
      |-> fetch_gnt_o && !seq_gnt;
  endproperty
  a_rr: assert property (p_rr) // R10
    else $error("fetch not given its turn");

  property p_tag;
    step_we_o && step_o.inval |-> step_o.tag == (4'h1 << step_o.way);
  endproperty
  a_tag: assert property (p_tag) // R12
    else $error("invalidate tag is not one-hot by way");

  property p_done;
    adv && last |=> st_idle && !status[16];
  endproperty
  a_done: assert property (p_done) // R7 R21
    else $error("active not cleared after last way");

  c_copyback: cover property (st_idle && launch && (opc == OPC_COPYBACK));
  c_inval: cover property (st_idle && launch && (opc == OPC_INVAL));
  c_push: cover property (cb_fire);
  c_abort: cover property (abort_now);
endmodule // ccs_seq
`default_nettype wire

/* File: ccs_way_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccs_way_model
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // way state
  input wire ccs_step_t step_i,
  input wire logic step_we_i,
  output logic way_dirty_o,
  // copyback buffer
  input wire logic cb_valid_i,
  input wire logic slow_i,
  output logic cb_ready_o,
  output logic [9:0] cb_cnt_o,
  output logic cb_bad_o
);
  logic [511:0] dirty_ff;
  logic tog_ff;
  logic [8:0] pos;
  assign pos = {step_i.set, step_i.way};
  assign way_dirty_o = dirty_ff[pos];
  // a slow buffer takes a way only every other cycle
  assign cb_ready_o = slow_i ? tog_ff : 1'b1;
  always @(posedge core_clk_i) begin
    tog_ff <= rstn_i & ~tog_ff;
    if (!rstn_i) begin
      cb_cnt_o <= 10'h0;
      cb_bad_o <= 1'b0;
    end else if (cb_valid_i && cb_ready_o) begin
      cb_cnt_o <= cb_cnt_o + 10'h1;
      cb_bad_o <= cb_bad_o | ~dirty_ff[pos];
    end
    if (step_we_i) begin
      dirty_ff[pos] <= 1'b0;
    end
  end
endmodule // ccs_way_model
`default_nettype wire
